// ===== spihse_consts.svh
// constants for the serial host shift engine
`ifndef SPIHSE_CONSTS_SVH
`define SPIHSE_CONSTS_SVH

// ==========================================================
// register offsets
`define SPIHSE_OFF_CONTROL  3'h0
`define SPIHSE_OFF_STATUS   3'h1
`define SPIHSE_OFF_DATA0    3'h2
`define SPIHSE_OFF_DATA1    3'h3
`define SPIHSE_OFF_DATA2    3'h4
`define SPIHSE_OFF_DATA3    3'h5
`define SPIHSE_OFF_DEBUG    3'h6

// ==========================================================
// control register fields
`define SPIHSE_CTL_CPOL     7
`define SPIHSE_CTL_CPHA     6
`define SPIHSE_CTL_LEN_HI   5
`define SPIHSE_CTL_LEN_LO   4
`define SPIHSE_CTL_MAN      3
`define SPIHSE_CTL_SEL_HI   2
`define SPIHSE_CTL_SEL_LO   0

// ==========================================================
// status register fields
`define SPIHSE_ST_IRQSEL_HI 7
`define SPIHSE_ST_IRQSEL_LO 6
`define SPIHSE_ST_CLK_HI    5
`define SPIHSE_ST_CLK_LO    4
`define SPIHSE_ST_ROUTE     3
`define SPIHSE_ST_LSB       2
`define SPIHSE_ST_EXTIRQ    1
`define SPIHSE_ST_BUSY      0
`define SPIHSE_ST_WMASK     8'hFC

// ==========================================================
// debug register fields
`define SPIHSE_DBG_SLOT     2
`define SPIHSE_DBG_LOOP     1
`define SPIHSE_DBG_WMASK    8'h06

// ==========================================================
// select encodings and counts
`define SPIHSE_SEL_NONE     3'h0
`define SPIHSE_SEL_T0       3'h1
`define SPIHSE_SEL_T1       3'h2
`define SPIHSE_RESET_BYTE   8'h00
`define SPIHSE_BITS_8       6'h08
`define SPIHSE_DIV_BASE     6'h20

`endif

// ===== spihse_pkg.sv
// types for the serial host shift engine
package spihse_pkg;
    typedef enum logic [1:0] {
        SPIHSE_IDLE,
        SPIHSE_LEAD,
        SPIHSE_TRAIL
    } spihse_state_type;
endpackage

// ===== spihse_divider.sv
// serial clock rate divider producing one-cycle enable pulses
`timescale 1ns/1ps
`include "spihse_consts.svh"

module spihse_divider #(
    parameter int CNT_W = 6
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // control
    input  wire logic             run,
    input  wire logic [1:0]       rate,
    // half-period tick
    output logic                  tick
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } spihse_div_state_type;

    spihse_div_state_type state_reg;
    spihse_div_state_type state_next;
    logic [CNT_W-1:0]     half;

    // half period in clocks: 16, 8, 4, 2 for rate 00..11
    assign half = CNT_W'((`SPIHSE_DIV_BASE >> rate) >> 1);

    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (!run) begin
            state_next.cnt = '0;
        end else if (state_reg.cnt == half - CNT_W'(1)) begin
            state_next.cnt = '0;
            state_next.tick = 1'b1;
        end else begin
            state_next.cnt = state_reg.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick = state_reg.tick;
endmodule

// ===== spihse_engine.sv
// serial host shift engine with register port and target selects
`timescale 1ns/1ps
`include "spihse_consts.svh"

module spihse_engine #(
    parameter int DATA_W = 32,
    parameter int CNT_W  = 6
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // serial link
    output logic             sclk,
    output logic             mosi,
    input  wire logic        miso,
    output logic             target_select_0_n,
    output logic             target_select_1_n,
    // interrupt side
    input  wire logic        expansion_irq_pin_n,
    output logic             irq_request,
    output logic [1:0]       irq_line,
    output logic             irq_slot_drive_n
);
    typedef struct packed {
        spihse_pkg::spihse_state_type fsm;
        logic [7:0]        ctl;
        logic [7:0]        st;
        logic [7:0]        dbg;
        logic [DATA_W-1:0] data;
        logic [CNT_W-1:0]  bits_left;
        logic              busy;
        logic              sclk;
        logic              mosi;
        logic              ss0_n;
        logic              ss1_n;
        logic              irq;
        logic              slot_n;
        logic [7:0]        rdata;
    } spihse_core_type;

    spihse_core_type s_reg;
    spihse_core_type s_next;
    logic            tick;
    logic            run;
    logic            serial_in;
    logic [CNT_W-1:0] frame_bits;
    logic            lsb_first;
    logic            cpol;
    logic            cpha;
    logic [2:0]      sel;
    logic            ext_irq;

    // ==========================================================
    // rate divider
    assign run = (s_reg.fsm != spihse_pkg::SPIHSE_IDLE);

    spihse_divider #(
        .CNT_W (CNT_W)
    ) u_div (
        .clk  (clk),
        .rstn (rstn),
        .run  (run),
        .rate (s_reg.st[`SPIHSE_ST_CLK_HI:`SPIHSE_ST_CLK_LO]),
        .tick (tick)
    );

    // ==========================================================
    // decoded fields
    assign lsb_first  = s_reg.st[`SPIHSE_ST_LSB];
    assign cpol       = s_reg.ctl[`SPIHSE_CTL_CPOL];
    assign cpha       = s_reg.ctl[`SPIHSE_CTL_CPHA];
    assign sel        = s_reg.ctl[`SPIHSE_CTL_SEL_HI:`SPIHSE_CTL_SEL_LO];
    // 8 bits per length step
    assign frame_bits = CNT_W'({1'b0,
        s_reg.ctl[`SPIHSE_CTL_LEN_HI:`SPIHSE_CTL_LEN_LO]} + 3'h1)
        * `SPIHSE_BITS_8;
    // loopback takes the bit being driven; pin keeps driving
    assign serial_in  = s_reg.dbg[`SPIHSE_DBG_LOOP] ? s_reg.mosi
                                                     : miso;
    // pin is a level, external interrupt mirrors it
    assign ext_irq    = ~expansion_irq_pin_n;

    // bit to present on mosi for the current data word
    function automatic logic out_bit(input logic [DATA_W-1:0] d,
                                     input logic lsb,
                                     input logic [CNT_W-1:0] nbits);
        logic r;
        r = 1'b0;
        if (lsb) begin
            // low end of the frame lies at bit DATA_W-nbits
            r = d[DATA_W - int'(nbits)];
        end else begin
            r = d[DATA_W-1];
        end
        return r;
    endfunction

    always_comb begin
        s_next = s_reg;
        s_next.rdata = 8'h00;

        // ======================================================
        // status flags
        s_next.st[`SPIHSE_ST_EXTIRQ] = ext_irq;
        // the pin only feeds the status flag, so the request stays low
        s_next.irq = 1'b0;
        s_next.slot_n = ~s_reg.dbg[`SPIHSE_DBG_SLOT];

        // ======================================================
        // register writes
        if (reg_wr) begin
            case (reg_addr)
                `SPIHSE_OFF_CONTROL: s_next.ctl = reg_wdata;
                `SPIHSE_OFF_STATUS: begin
                    s_next.st = (reg_wdata & `SPIHSE_ST_WMASK)
                        | (s_next.st & ~`SPIHSE_ST_WMASK);
                end
                `SPIHSE_OFF_DATA0: s_next.data[7:0]   = reg_wdata;
                `SPIHSE_OFF_DATA1: s_next.data[15:8]  = reg_wdata;
                `SPIHSE_OFF_DATA2: s_next.data[23:16] = reg_wdata;
                `SPIHSE_OFF_DATA3: s_next.data[31:24] = reg_wdata;
                `SPIHSE_OFF_DEBUG: begin
                    s_next.dbg = reg_wdata & `SPIHSE_DBG_WMASK;
                end
                default: ;
            endcase
        end

        // ======================================================
        // shift machine
        case (s_reg.fsm)
            spihse_pkg::SPIHSE_IDLE: begin
                s_next.sclk = cpol;
                if (reg_wr && reg_addr == `SPIHSE_OFF_DATA3) begin
                    s_next.busy = 1'b1;
                    s_next.bits_left = frame_bits;
                    s_next.fsm = spihse_pkg::SPIHSE_LEAD;
                    s_next.mosi = out_bit(s_next.data, lsb_first,
                                          frame_bits);
                end
            end
            spihse_pkg::SPIHSE_LEAD: begin
                // first edge of a bit: sample unless phase delays it
                if (tick) begin
                    s_next.sclk = ~s_reg.sclk;
                    if (!cpha) begin
                        if (lsb_first) begin
                            s_next.data = {serial_in,
                                           s_reg.data[DATA_W-1:1]};
                        end else begin
                            s_next.data = {s_reg.data[DATA_W-2:0],
                                           serial_in};
                        end
                    end
                    s_next.fsm = spihse_pkg::SPIHSE_TRAIL;
                end
            end
            spihse_pkg::SPIHSE_TRAIL: begin
                if (tick) begin
                    s_next.sclk = ~s_reg.sclk;
                    if (cpha) begin
                        if (lsb_first) begin
                            s_next.data = {serial_in,
                                           s_reg.data[DATA_W-1:1]};
                        end else begin
                            s_next.data = {s_reg.data[DATA_W-2:0],
                                           serial_in};
                        end
                    end
                    s_next.bits_left = s_reg.bits_left - CNT_W'(1);
                    if (s_reg.bits_left == CNT_W'(1)) begin
                        s_next.busy = 1'b0;
                        s_next.fsm = spihse_pkg::SPIHSE_IDLE;
                    end else begin
                        s_next.mosi = out_bit(s_next.data, lsb_first,
                                              frame_bits);
                        s_next.fsm = spihse_pkg::SPIHSE_LEAD;
                    end
                end
            end
            default: s_next.fsm = spihse_pkg::SPIHSE_IDLE;
        endcase
        s_next.st[`SPIHSE_ST_BUSY] = s_next.busy;

        // ======================================================
        // target selects
        s_next.ss0_n = 1'b1;
        s_next.ss1_n = 1'b1;
        if (s_next.ctl[`SPIHSE_CTL_MAN] || s_next.busy) begin
            if (s_next.ctl[`SPIHSE_CTL_SEL_HI:`SPIHSE_CTL_SEL_LO]
                    == `SPIHSE_SEL_T0) begin
                s_next.ss0_n = 1'b0;
            end else if (s_next.ctl[`SPIHSE_CTL_SEL_HI:`SPIHSE_CTL_SEL_LO]
                    == `SPIHSE_SEL_T1) begin
                s_next.ss1_n = 1'b0;
            end
        end

        // ======================================================
        // register reads, data valid the next cycle
        if (reg_rd) begin
            case (reg_addr)
                `SPIHSE_OFF_CONTROL: s_next.rdata = s_reg.ctl;
                `SPIHSE_OFF_STATUS:  s_next.rdata = s_reg.st;
                `SPIHSE_OFF_DATA0:   s_next.rdata = s_reg.data[7:0];
                `SPIHSE_OFF_DATA1:   s_next.rdata = s_reg.data[15:8];
                `SPIHSE_OFF_DATA2:   s_next.rdata = s_reg.data[23:16];
                `SPIHSE_OFF_DATA3:   s_next.rdata = s_reg.data[31:24];
                `SPIHSE_OFF_DEBUG:   s_next.rdata = s_reg.dbg;
                default:             s_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.fsm <= spihse_pkg::SPIHSE_IDLE;
            s_reg.ss0_n <= 1'b1;
            s_reg.ss1_n <= 1'b1;
            s_reg.slot_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // outputs, all from flops
    assign reg_rdata         = s_reg.rdata;
    assign sclk              = s_reg.sclk;
    assign mosi              = s_reg.mosi;
    assign target_select_0_n = s_reg.ss0_n;
    assign target_select_1_n = s_reg.ss1_n;
    assign irq_request       = s_reg.irq;
    assign irq_line = s_reg.st[`SPIHSE_ST_IRQSEL_HI:`SPIHSE_ST_IRQSEL_LO];
    assign irq_slot_drive_n  = s_reg.slot_n;
endmodule

// ===== spihse_target.sv
// serial target model answering frames on the link
`timescale 1ns/1ps

module spihse_target (
    // link
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic        cs_n,
    output logic             miso,
    // frame contents
    input  wire logic [31:0] tx,
    output logic [31:0]      rx
);
    logic [31:0] sh;
    initial begin
        miso = 1'b0;
        rx = 32'h0;
        sh = 32'h0;
    end
    always @(negedge cs_n) begin
        sh = tx;
        rx = 32'h0;
        miso = tx[31];
    end
    // mode 0: sample on the rising edge, next bit after the falling one
    always @(posedge sclk) if (!cs_n) rx = {rx[30:0], mosi};
    always @(negedge sclk) if (!cs_n) begin
        sh = sh << 1;
        miso = sh[31];
    end
    // released line flips so a stale bit never looks valid
    always @(posedge cs_n) miso = ~miso;
endmodule

// ===== spihse_engine_checker.sv
// concurrent checks on the ports of the serial host shift engine
`timescale 1ns/1ps

module spihse_engine_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // link and interrupt side
    input wire logic       sclk,
    input wire logic       target_select_0_n,
    input wire logic       target_select_1_n,
    input wire logic       irq_request,
    input wire logic [1:0] irq_line,
    input wire logic       irq_slot_drive_n
);
    // ==========================================================
    // shadow copies of the writable fields
    logic [7:0] ctl_s;
    logic [7:0] st_s;
    logic [7:0] dbg_s;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl_s <= 8'h00;
            st_s  <= 8'h00;
            dbg_s <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == 3'h0) ctl_s <= reg_wdata;
            if (reg_addr == 3'h1) st_s <= reg_wdata;
            if (reg_addr == 3'h6) dbg_s <= reg_wdata;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_irq_held_low: assert property (irq_request == 1'b0)
        else $error("interrupt request raised");
    a_irq_line_copy: assert property (!$past(reg_wr) |->
        irq_line == st_s[7:6]) else $error("irq line differs from field");
    a_slot_gate: assert property (!$past(reg_wr) |->
        irq_slot_drive_n == !dbg_s[2]) else $error("slot drive wrong");
    a_rdata_quiet: assert property (!reg_rd |=>
        reg_rdata == 8'h00) else $error("read data outside read slot");
    a_auto_start: assert property (reg_wr && reg_addr == 3'h5 &&
        !ctl_s[3] && ctl_s[2:0] == 3'h1 && target_select_0_n &&
        target_select_1_n |=> !target_select_0_n)
        else $error("frame start did not select");
    a_manual_sel: assert property (ctl_s[3] && !$past(reg_wr) |->
        target_select_0_n == (ctl_s[2:0] != 3'h1) &&
        target_select_1_n == (ctl_s[2:0] != 3'h2))
        else $error("manual select mismatch");
    a_bad_sel_none: assert property (ctl_s[2:0] > 3'h2 &&
        !$past(reg_wr) |-> target_select_0_n && target_select_1_n)
        else $error("undefined select drove a line");
    a_fast_half: assert property ($changed(sclk) &&
        st_s[5:4] == 2'h3 |=> $stable(sclk)) else $error("fast rate");
    a_slow_half: assert property ($changed(sclk) &&
        st_s[5:4] == 2'h0 |=> $stable(sclk) [*8])
        else $error("slow rate");
endmodule

bind spihse_engine spihse_engine_checker u_chk (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk(sclk),
    .target_select_0_n(target_select_0_n),
    .target_select_1_n(target_select_1_n), .irq_request(irq_request),
    .irq_line(irq_line), .irq_slot_drive_n(irq_slot_drive_n));

// ===== spihse_engine_test.sv
// self-checking testbench for the serial host shift engine
`timescale 1ns/1ps

module spihse_engine_test;
    // ==========================================================
    // stimulus and observed signals
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        irq_pin_n = 1'b1;
    logic [7:0]  reg_rdata;
    logic        sclk;
    logic        mosi;
    logic        miso;
    logic        ts0_n;
    logic        ts1_n;
    logic        irq_req;
    logic        slot_n;
    logic [1:0]  irq_line;
    logic [31:0] tgt_tx = 32'h0;
    logic [31:0] tgt_rx;
    logic [7:0]  v;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cyc = 0;

    always #2.5 clk = ~clk;

    spihse_engine DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sclk(sclk), .mosi(mosi), .miso(miso),
        .target_select_0_n(ts0_n), .target_select_1_n(ts1_n),
        .expansion_irq_pin_n(irq_pin_n), .irq_request(irq_req),
        .irq_line(irq_line), .irq_slot_drive_n(slot_n));
    spihse_target u_tgt (.sclk(sclk), .mosi(mosi), .cs_n(ts0_n & ts1_n),
        .miso(miso), .tx(tgt_tx), .rx(tgt_rx));

    // ==========================================================
    // bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        rd(a);
        chk(v, e);
    endtask
    // polls busy; a slow 32-bit frame needs about 512 polls
    task automatic wait_idle;
        int i;
        i = 0;
        rd(3'h1);
        while (v[0] !== 1'b0 && i < 600) begin
            rd(3'h1);
            i++;
        end
        chk(v[0], 1'b0);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs;
        rchk(3'h0, 8'h00);
        rchk(3'h6, 8'h00);
        wr(3'h6, 8'hFF);
        rchk(3'h6, 8'h06);
        chk(slot_n, 1'b0);
        wr(3'h7, 8'hFF);
        rchk(3'h7, 8'h00);
        wr(3'h1, 8'hFF);
        rchk(3'h1, 8'hFC);
        chk(irq_line, 2'h3);
        irq_pin_n <= 1'b0;
        rchk(3'h1, 8'hFE);
        chk(irq_req, 1'b0);
        irq_pin_n <= 1'b1;
        rchk(3'h1, 8'hFC);
        wr(3'h6, 8'h00);
        rchk(3'h6, 8'h00);
        chk(slot_n, 1'b1);
    endtask
    task automatic t_msb;
        wr(3'h0, 8'h01);
        wr(3'h1, 8'h30);
        tgt_tx = 32'h3C00_0000;
        wr(3'h4, 8'h5A);
        wr(3'h5, 8'hA5);
        rd(3'h1);
        chk(v[0], 1'b1);
        chk(ts0_n, 1'b0);
        wait_idle;
        chk(tgt_rx[7:0], 8'hA5);
        rchk(3'h2, 8'h3C);
        rchk(3'h5, 8'h5A);
        chk(ts0_n, 1'b1);
    endtask
    // loopback with the second target watching the wire
    task automatic t_lsb;
        wr(3'h0, 8'h12);
        wr(3'h1, 8'h34);
        wr(3'h6, 8'h02);
        wr(3'h4, 8'h03);
        wr(3'h5, 8'h00);
        rd(3'h1);
        chk(ts1_n, 1'b0);
        wait_idle;
        chk(tgt_rx[15:0], 16'hC000);
        rchk(3'h5, 8'h00);
        rchk(3'h4, 8'h03);
        wr(3'h6, 8'h00);
    endtask
    // idle-high clock, trailing-edge sampling, looped back
    task automatic t_mode;
        wr(3'h0, 8'hC1);
        wr(3'h1, 8'h30);
        chk(sclk, 1'b1);
        wr(3'h6, 8'h02);
        wr(3'h5, 8'h96);
        wait_idle;
        chk(sclk, 1'b1);
        rchk(3'h2, 8'h96);
        rchk(3'h5, 8'h03);
        wr(3'h6, 8'h00);
    endtask
    task automatic t_manual;
        for (int s = 0; s < 8; s++) begin
            logic [1:0] e;
            e = (s == 1) ? 2'b10 : (s == 2) ? 2'b01 : 2'b11;
            wr(3'h0, 8'h08 | s[7:0]);
            rchk(3'h0, 8'h08 | s[7:0]);
            chk({ts1_n, ts0_n}, e);
        end
    endtask
    // 32 bits at the slowest rate take 1024 clocks
    task automatic t_slow;
        wr(3'h0, 8'h30);
        wr(3'h1, 8'h00);
        wr(3'h5, 8'h00);
        repeat (800) @(posedge clk);
        rd(3'h1);
        chk(v[0], 1'b1);
        chk({ts1_n, ts0_n}, 2'b11);
        wait_idle;
    endtask

    // ==========================================================
    // run control
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_msb;
        t_lsb;
        t_mode;
        t_manual;
        t_slow;
        test_done;
    end
endmodule
